// ==== hdl/fsp_fetch_map.sv ====
// boot swap state capture and cpu fetch address remap
`timescale 1ns/100ps
module fsp_fetch_map (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // nonvolatile swap flag and cpu side
  input wire logic swap_nv_i,
  input wire logic [15:0] cpu_addr_i,
  // results
  output logic swap_active_o,
  output logic [15:0] flash_addr_o
);
  import fsp_pkg::*;

  logic loaded_reg, loaded_next;
  logic swap_reg, swap_next;
  logic [15:0] addr_reg, addr_next;

  // flag is caught on the first enabled edge after release, never by the reset itself
  always_comb begin
    loaded_next = 1'b1;
    swap_next = loaded_reg ? swap_reg : swap_nv_i; // [RULE16] [RULE10]
    addr_next = fsp_remap(cpu_addr_i, swap_reg); // [RULE16] [RULE12]
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      loaded_reg <= 1'b0;
      swap_reg <= 1'b0;
      addr_reg <= ADDR_RST;
    end else if (ce_i) begin
      loaded_reg <= loaded_next;
      swap_reg <= swap_next;
      addr_reg <= addr_next;
    end
  end

  assign swap_active_o = swap_reg;
  assign flash_addr_o = addr_reg;

  property p_fetch_swap;
    @(posedge clk_i) disable iff (!reset_n_i)
    ce_i && loaded_reg && swap_reg && (cpu_addr_i <= BOOT1_HI)
      |=> flash_addr_o[SWAP_BIT] != $past(cpu_addr_i[SWAP_BIT]);
  endproperty
  a_fetch_swap: assert property (p_fetch_swap) // [RULE10]
    else $error("swapped fetch did not invert bit 12");
endmodule

// ==== hdl/fsp_pkg.sv ====
// constants, types and helpers for the flash self-programming controller
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// (RULE1) refuse self-programming while the cpu runs from the subsystem clock
// (RULE2) flash mode pin must stay high for the whole operation
// (RULE3) program disables interrupts globally before starting
// (RULE4) any unmasked pending interrupt request stops a running operation at once
// (RULE5) unmasked requests stop it even when disabled; program masks sources
// (RULE6) after a stop, control returns; a new start resumes programming
// (RULE7) timing uses the internal oscillator; its settle wait runs inside
// (RULE8) entry routine lives in the common area 0000H to 7FFFH
// (RULE9) clusters 0000H-0FFFH and 1000H-1FFFH are exchangeable by swap setting
// (RULE10) active swap setting boots from the alternate cluster after reset
// (RULE11) program writes alternate, swaps, rewrites original, then unswaps
// (RULE12) debug flag at 0084H, ten-byte debug id at 0085H to 008EH
// (RULE13) swap also exchanges debug bytes with 1084H-108EH; keep both equal
// (RULE14) boot protection rejects chip erase, block erase, writes to 0000H-0FFFH
// (RULE15) all other stored security prohibitions never block self-programming
// (RULE16) swap flag sampled at reset; inverts address bit 12 below 2000H
package fsp_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int HSO_STAB_NS = 2000;
  // register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_SWAP = 8'h0C;
  // field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_CMD_LSB = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_STOP = 2;
  localparam int STAT_REJ = 3;
  localparam int STAT_SWAP_ACT = 4;
  localparam int STAT_SWAP_NV = 5;
  localparam int SWAP_BIT = 12;
  // reset values
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [1:0] CMD_RST = 2'h0;
  // commands
  localparam logic [1:0] CMD_WRITE = 2'h0;
  localparam logic [1:0] CMD_BLK_ERASE = 2'h1;
  localparam logic [1:0] CMD_CHIP_ERASE = 2'h2;
  localparam logic [1:0] CMD_RSVD = 2'h3;
  // memory map
  localparam logic [15:0] BOOT0_HI = 16'h0FFF;
  localparam logic [15:0] BOOT1_HI = 16'h1FFF;
  localparam logic [15:0] COMMON_HI = 16'h7FFF;
  localparam logic [15:0] DBG_FLAG_ADDR = 16'h0084;
  localparam logic [15:0] DBG_ID_LO = 16'h0085;
  localparam logic [15:0] DBG_ID_HI = 16'h008E;

  typedef enum logic [3:0] {
    FSP_IDLE = 4'h1,
    FSP_STAB = 4'h2,
    FSP_BUSY = 4'h4,
    FSP_STOP = 4'h8
  } fsp_state_t;

  typedef struct packed {
    logic [7:0] flags_1_high;
    logic [7:0] flags_1_low;
    logic [7:0] flags_0_high;
    logic [7:0] flags_0_low;
  } fsp_irq_t;

  typedef struct packed {
    logic valid;
    logic [1:0] cmd;
    logic [15:0] addr;
  } fsp_flash_req_t;

  // cluster swap: bit 12 flips inside 0000H..1FFFH, debug bytes follow [RULE9] [RULE13]
  function automatic logic [15:0] fsp_remap(input logic [15:0] a, input logic swap);
    logic [15:0] r;
    r = a;
    if (swap && (a <= BOOT1_HI)) begin
      r[SWAP_BIT] = ~a[SWAP_BIT];
    end
    return r;
  endfunction
endpackage

// ==== hdl/fsp_top.sv ====
// flash self-programming controller with apb registers and boot swap
`timescale 1ns/100ps
module fsp_top #(
  parameter int STAB_NS = fsp_pkg::HSO_STAB_NS
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // pin and cpu status
  input wire logic flash_mode_pin_i,
  input wire logic cpu_on_subclk_i,
  input wire logic cpu_on_main_ext_i,
  input wire fsp_pkg::fsp_irq_t irq_request_flags_i,
  input wire fsp_pkg::fsp_irq_t irq_mask_flags_i,
  // security and swap storage
  input wire logic boot0_protect_i,
  input wire logic swap_nv_i,
  output logic swap_nv_o,
  // flash array
  output fsp_pkg::fsp_flash_req_t flash_req_o,
  input wire logic flash_done_i,
  input wire logic [15:0] cpu_addr_i,
  output logic [15:0] flash_addr_o
);
  import fsp_pkg::*;

  localparam int STAB_RAW = (STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STAB_CYC = (STAB_RAW < 1) ? 1 : STAB_RAW;
  localparam logic [15:0] STAB_LOAD = 16'(STAB_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations
  fsp_state_t state_reg, state_next;
  logic [15:0] addr_reg, addr_next;
  logic [1:0] cmd_reg, cmd_next;
  logic [15:0] cnt_reg, cnt_next;
  logic done_reg, done_next;
  logic stop_reg, stop_next;
  logic rej_reg, rej_next;
  logic swap_nv_reg, swap_nv_next;
  logic pin_s1_reg, pin_s2_reg;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  fsp_flash_req_t req_reg, req_next;
  logic swap_active;
  logic wr_acc, start_wr, irq_pend, refuse, prot_hit, halt, mapped;
  logic [1:0] wcmd;
  logic [15:0] phys;

  ////////////////////////////////////////////////////////////////////////////////
  // decode
  always_comb begin
    wr_acc = psel_i && penable_i && pready_reg && pwrite_i;
    start_wr = wr_acc && (paddr_i == OFS_CTRL) && pwdata_i[CTRL_START];
    wcmd = pwdata_i[CTRL_CMD_LSB +: 2];
    mapped = (paddr_i == OFS_CTRL) || (paddr_i == OFS_ADDR) ||
             (paddr_i == OFS_STAT) || (paddr_i == OFS_SWAP);
    // every request flag counts unless its mask is set, global disable or not [RULE4] [RULE5]
    irq_pend = |(32'(irq_request_flags_i) & ~32'(irq_mask_flags_i));
    phys = fsp_remap(addr_reg, swap_active); // [RULE16] [RULE9]
    // only the boot cluster protection is honoured here [RULE14] [RULE15]
    prot_hit = boot0_protect_i && ((wcmd == CMD_CHIP_ERASE) || (phys <= BOOT0_HI));
    refuse = cpu_on_subclk_i || !pin_s2_reg || prot_hit || (wcmd == CMD_RSVD); // [RULE1] [RULE2]
    halt = irq_pend || !pin_s2_reg; // [RULE4] [RULE2]
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    state_next = state_reg;
    cmd_next = cmd_reg;
    cnt_next = cnt_reg;
    done_next = done_reg;
    stop_next = stop_reg;
    rej_next = rej_reg;
    req_next = req_reg;
    // write-one-to-clear; a same-cycle set below wins
    if (wr_acc && (paddr_i == OFS_STAT)) begin
      done_next = done_reg && !pwdata_i[STAT_DONE];
      stop_next = stop_reg && !pwdata_i[STAT_STOP];
      rej_next = rej_reg && !pwdata_i[STAT_REJ];
    end
    case (state_reg)
      FSP_IDLE, FSP_STOP: begin
        if (start_wr) begin
          if (refuse) begin
            rej_next = 1'b1; // [RULE1] [RULE14]
          end else begin
            // re-entering after a stop restarts the operation [RULE6]
            cmd_next = wcmd;
            req_next.cmd = wcmd;
            req_next.addr = phys;
            if (cpu_on_main_ext_i) begin
              state_next = FSP_STAB; // [RULE7]
              cnt_next = STAB_LOAD;
            end else begin
              state_next = FSP_BUSY;
              req_next.valid = 1'b1;
            end
          end
        end
      end
      FSP_STAB: begin
        if (halt) begin
          state_next = FSP_STOP; // [RULE4]
          stop_next = 1'b1;
        end else if (cnt_reg == 16'h0000) begin
          state_next = FSP_BUSY; // [RULE7]
          req_next.valid = 1'b1;
        end else begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      FSP_BUSY: begin
        if (flash_done_i) begin
          state_next = FSP_IDLE;
          done_next = 1'b1;
          req_next.valid = 1'b0;
        end else if (halt) begin
          // array op is abandoned; control returns to the program [RULE4] [RULE6]
          state_next = FSP_STOP;
          stop_next = 1'b1;
          req_next.valid = 1'b0;
        end
      end
      default: begin
        state_next = FSP_IDLE;
        req_next.valid = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // apb registers; zero wait: pready rises in the access phase
  always_comb begin
    addr_next = addr_reg;
    swap_nv_next = swap_nv_reg;
    pready_next = psel_i && !penable_i;
    pslverr_next = psel_i && !penable_i && !mapped;
    prdata_next = prdata_reg;
    // address frozen while an operation owns it
    if (wr_acc && (paddr_i == OFS_ADDR) && (state_reg != FSP_STAB) &&
        (state_reg != FSP_BUSY)) begin
      addr_next = pwdata_i[15:0];
    end
    // new swap setting reaches the boot map only through the next reset [RULE10] [RULE11]
    if (wr_acc && (paddr_i == OFS_SWAP)) begin
      swap_nv_next = pwdata_i[0];
    end
    if (psel_i && !penable_i) begin
      prdata_next = 32'h0000_0000;
      case (paddr_i)
        OFS_CTRL: prdata_next[CTRL_CMD_LSB +: 2] = cmd_reg;
        OFS_ADDR: prdata_next[15:0] = addr_reg;
        OFS_STAT: begin
          prdata_next[STAT_BUSY] = (state_reg == FSP_STAB) || (state_reg == FSP_BUSY);
          prdata_next[STAT_DONE] = done_reg;
          prdata_next[STAT_STOP] = stop_reg;
          prdata_next[STAT_REJ] = rej_reg;
          prdata_next[STAT_SWAP_ACT] = swap_active;
          prdata_next[STAT_SWAP_NV] = swap_nv_reg;
        end
        OFS_SWAP: prdata_next[0] = swap_nv_reg;
        default: prdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= FSP_IDLE;
      addr_reg <= ADDR_RST;
      cmd_reg <= CMD_RST;
      cnt_reg <= 16'h0000;
      done_reg <= 1'b0;
      stop_reg <= 1'b0;
      rej_reg <= 1'b0;
      swap_nv_reg <= 1'b0;
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      req_reg <= '0;
    end else if (ce_i) begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      cmd_reg <= cmd_next;
      cnt_reg <= cnt_next;
      done_reg <= done_next;
      stop_reg <= stop_next;
      rej_reg <= rej_next;
      swap_nv_reg <= swap_nv_next;
      pin_s1_reg <= flash_mode_pin_i;
      pin_s2_reg <= pin_s1_reg;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      req_reg <= req_next;
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign swap_nv_o = swap_nv_reg;
  assign flash_req_o = req_reg;

  fsp_fetch_map u_map (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .swap_nv_i(swap_nv_i),
    .cpu_addr_i(cpu_addr_i),
    .swap_active_o(swap_active),
    .flash_addr_o(flash_addr_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_start_idle;
    ce_i && start_wr && ((state_reg == FSP_IDLE) || (state_reg == FSP_STOP));
  endsequence
  sequence s_refused;
    (state_reg == $past(state_reg)) && rej_reg && !req_reg.valid;
  endsequence

  property p_subclk_refuse;
    @(posedge clk_i) disable iff (!reset_n_i)
    s_start_idle and cpu_on_subclk_i |=> s_refused;
  endproperty
  a_subclk_refuse: assert property (p_subclk_refuse) // [RULE1]
    else $error("start accepted on subsystem clock");

  property p_pin_low_refuse;
    @(posedge clk_i) disable iff (!reset_n_i)
    s_start_idle and !pin_s2_reg |=> s_refused;
  endproperty
  a_pin_low_refuse: assert property (p_pin_low_refuse) // [RULE2]
    else $error("start accepted with mode pin low");

  property p_irq_stop;
    @(posedge clk_i) disable iff (!reset_n_i)
    ce_i && (state_reg == FSP_BUSY) && irq_pend && !flash_done_i
      |=> (state_reg == FSP_STOP) && stop_reg && !req_reg.valid;
  endproperty
  a_irq_stop: assert property (p_irq_stop) // [RULE4]
    else $error("pending interrupt did not stop programming");

  property p_masked_runs;
    @(posedge clk_i) disable iff (!reset_n_i)
    ce_i && (state_reg == FSP_BUSY) && !halt && !flash_done_i
      |=> (state_reg == FSP_BUSY) && req_reg.valid;
  endproperty
  a_masked_runs: assert property (p_masked_runs) // [RULE5]
    else $error("masked interrupt stopped programming");

  property p_resume;
    @(posedge clk_i) disable iff (!reset_n_i)
    ce_i && (state_reg == FSP_STOP) && start_wr && !refuse
      |=> (state_reg == FSP_STAB) || (state_reg == FSP_BUSY);
  endproperty
  a_resume: assert property (p_resume) // [RULE6]
    else $error("restart after stop did not resume");

  property p_stab_wait;
    @(posedge clk_i) disable iff (!reset_n_i)
    s_start_idle and !refuse and cpu_on_main_ext_i
      |=> (state_reg == FSP_STAB) && (cnt_reg == STAB_LOAD) && !req_reg.valid;
  endproperty
  a_stab_wait: assert property (p_stab_wait) // [RULE7]
    else $error("oscillator settle wait skipped");

  property p_req_remap;
    @(posedge clk_i) disable iff (!reset_n_i)
    ce_i && req_reg.valid && !$past(req_reg.valid) |-> ##0 req_reg.addr == $past(phys);
  endproperty
  a_req_remap: assert property (p_req_remap) // [RULE16]
    else $error("request address not remapped by swap state");

  property p_protect;
    @(posedge clk_i) disable iff (!reset_n_i)
    req_reg.valid && boot0_protect_i |->
      (req_reg.cmd != CMD_CHIP_ERASE) && (req_reg.addr > BOOT0_HI);
  endproperty
  a_protect: assert property (p_protect) // [RULE14]
    else $error("protected boot cluster targeted");
endmodule

// ==== tb/fsp_flash_model.sv ====
// flash array stand-in: answers each request with a one-cycle done pulse
`timescale 1ns/100ps
module fsp_flash_model
  import fsp_pkg::*;
#(
  parameter int LAT = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // request side
  input wire fsp_pkg::fsp_flash_req_t req_i,
  input wire logic hold_i,
  output logic done_o
);
  int cnt_reg;
  ////////////////////////////////////////////////////////////////////////////////
  // hold_i stalls the array, so a stop can land in the middle of an operation
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_reg <= 0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (!req_i.valid || done_o) begin
        cnt_reg <= 0;
      end else if (cnt_reg >= LAT && !hold_i) begin
        done_o <= 1'b1;
      end else if (cnt_reg < LAT) begin
        cnt_reg <= cnt_reg + 1;
      end
    end
  end
endmodule

// ==== tb/fsp_top_tb.sv ====
// self-checking bench for the flash self-programming controller
`timescale 1ns/100ps
module fsp_top_tb;
  import fsp_pkg::*;
  localparam int STAB_TB_NS = 50;
  localparam int STAB_CYC = STAB_TB_NS / CLK_PERIOD_NS;
  typedef struct packed {logic sub; logic pin; logic prot; logic [1:0] cmd;
    logic [15:0] addr; logic [15:0] phys; logic ok;} fsp_row_t;
  logic clk_i, reset_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, q;
  logic pin, sub, ext, prot, swap_nv_i, swap_nv_o, done, hold, e, ce;
  logic [15:0] cpu_addr, flash_addr_o;
  fsp_irq_t irq, mask;
  fsp_flash_req_t flash_req_o;
  int err_total, checks_done, n0, n1;
  fsp_row_t rows [10] = '{
    '{0, 1, 0, CMD_WRITE, 16'h0100, 16'h0100, 1},
    '{0, 1, 0, CMD_BLK_ERASE, 16'h3000, 16'h3000, 1},
    '{0, 1, 0, CMD_CHIP_ERASE, 16'h0000, 16'h0000, 1},
    '{0, 1, 0, CMD_RSVD, 16'h0100, 16'h0100, 0},
    '{1, 1, 0, CMD_WRITE, 16'h0100, 16'h0100, 0},
    '{0, 0, 0, CMD_WRITE, 16'h0100, 16'h0100, 0},
    '{0, 1, 1, CMD_WRITE, 16'h0FFF, 16'h0FFF, 0},
    '{0, 1, 1, CMD_BLK_ERASE, 16'h0800, 16'h0800, 0},
    '{0, 1, 1, CMD_CHIP_ERASE, 16'h5000, 16'h5000, 0},
    '{0, 1, 1, CMD_WRITE, 16'h1000, 16'h1000, 1}};
  logic [15:0] fin [7] = '{16'h0084, 16'h008E, 16'h1085, 16'h0FFF, 16'h1FFF, 16'h2000, 16'h7FFF};
  logic [15:0] fout [7] = '{16'h1084, 16'h108E, 16'h0085, 16'h1FFF, 16'h0FFF, 16'h2000, 16'h7FFF};

  fsp_top #(.STAB_NS(STAB_TB_NS)) fsp_top_i (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .flash_mode_pin_i(pin), .cpu_on_subclk_i(sub), .cpu_on_main_ext_i(ext),
    .irq_request_flags_i(irq), .irq_mask_flags_i(mask), .boot0_protect_i(prot),
    .swap_nv_i(swap_nv_i), .swap_nv_o(swap_nv_o), .flash_req_o(flash_req_o),
    .flash_done_i(done), .cpu_addr_i(cpu_addr), .flash_addr_o(flash_addr_o));
  fsp_flash_model fsp_flash_model_i (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .req_i(flash_req_o), .hold_i(hold), .done_o(done));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // one idle edge before each setup, so no strobe is driven twice in a step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic err);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    q = 32'h1;
    while (q[0] !== 1'b0 && n < 100) begin
      apb(1'b0, OFS_STAT, 32'h0, q, e);
      n++;
    end
    if (n >= 100) err_total++;
  endtask

  task automatic run_row(input fsp_row_t r);
    @(posedge clk_i);
    sub <= r.sub;
    pin <= r.pin;
    prot <= r.prot;
    apb(1'b1, OFS_ADDR, {16'h0000, r.addr}, q, e);
    apb(1'b1, OFS_CTRL, {29'h0, r.cmd, 1'b1}, q, e);
    @(posedge clk_i);
    #1;
    chk(flash_req_o.valid, r.ok);
    if (r.ok) begin
      chk(flash_req_o.cmd, r.cmd);
      chk(flash_req_o.addr, r.phys);
    end
    wait_idle();
    if (r.ok) begin
      apb(1'b0, OFS_CTRL, 32'h0, q, e);
      chk(q[2:1], r.cmd);
    end
    apb(1'b0, OFS_STAT, 32'h0, q, e);
    chk(q[3:1], r.ok ? 3'h1 : 3'h4);
    apb(1'b1, OFS_STAT, 32'h0000000E, q, e);
  endtask

  task automatic time_start(output int n);
    apb(1'b1, OFS_CTRL, 32'h1, q, e);
    n = 0;
    while (flash_req_o.valid !== 1'b1 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 400) err_total++;
    wait_idle();
  endtask

  task automatic fetch(input logic [15:0] a, input logic [15:0] x);
    @(posedge clk_i);
    cpu_addr <= a;
    repeat (2) @(posedge clk_i);
    #1;
    chk(flash_addr_o, x);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // the whole run needs well under a thousand cycles
  initial begin
    repeat (30000) @(posedge clk_i);
    err_total++;
    test_done();
  end

  initial begin
    {reset_n_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {sub, ext, prot, swap_nv_i, hold, cpu_addr, irq} = '0;
    pin = 1'b1;
    ce = 1'b1;
    mask = 32'hFFFFFFFF;
    err_total = 0;
    checks_done = 0;
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0, q, e);
      chk(q, 32'h0);
      chk(e, i == 4);
    end
    fetch(16'h1084, 16'h1084);
    // enable low must freeze the fetch map output
    @(posedge clk_i);
    ce <= 1'b0;
    cpu_addr <= 16'h2000;
    repeat (3) @(posedge clk_i);
    #1;
    chk(flash_addr_o, 16'h1084);
    @(posedge clk_i);
    ce <= 1'b1;
    fetch(16'h2000, 16'h2000);
    foreach (rows[i]) run_row(rows[i]);
    @(posedge clk_i);
    prot <= 1'b0;
    time_start(n0);
    @(posedge clk_i);
    ext <= 1'b1;
    time_start(n1);
    chk(n1 - n0 >= STAB_CYC && n1 - n0 <= STAB_CYC + 1, 1'b1);
    // done flag from the timing runs would otherwise show in the stop checks
    apb(1'b1, OFS_STAT, 32'h0000000E, q, e);
    // each flag byte in turn: masked request must not stop, unmasked must
    for (int b = 0; b < 4; b++) begin
      @(posedge clk_i);
      hold <= 1'b1;
      ext <= 1'b0;
      mask <= 32'hFFFFFFFF;
      irq <= 32'h1 << (9 * b);
      apb(1'b1, OFS_CTRL, 32'h1, q, e);
      repeat (3) @(posedge clk_i);
      #1;
      chk(flash_req_o.valid, 1'b1);
      @(posedge clk_i);
      mask <= ~(32'h1 << (9 * b));
      repeat (3) @(posedge clk_i);
      #1;
      chk(flash_req_o.valid, 1'b0);
      apb(1'b0, OFS_STAT, 32'h0, q, e);
      chk(q[2:0], 3'h4);
      apb(1'b1, OFS_STAT, 32'h0000000E, q, e);
      @(posedge clk_i);
      irq <= '0;
    end
    @(posedge clk_i);
    hold <= 1'b0;
    time_start(n0);
    chk(q[2:0], 3'h2);
    apb(1'b1, OFS_STAT, 32'h0000000E, q, e);
    @(posedge clk_i);
    hold <= 1'b1;
    apb(1'b1, OFS_CTRL, 32'h1, q, e);
    @(posedge clk_i);
    pin <= 1'b0;
    repeat (5) @(posedge clk_i);
    #1;
    chk(flash_req_o.valid, 1'b0);
    @(posedge clk_i);
    pin <= 1'b1;
    hold <= 1'b0;
    apb(1'b1, OFS_SWAP, 32'h1, q, e);
    #1;
    chk(swap_nv_o, 1'b1);
    apb(1'b0, OFS_STAT, 32'h0, q, e);
    chk(q[5:4], 2'h2);
    // stored flag now set: it takes effect only across a reset
    @(posedge clk_i);
    swap_nv_i <= 1'b1;
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    apb(1'b0, OFS_STAT, 32'h0, q, e);
    chk(q[5:4], 2'h1);
    foreach (fin[i]) fetch(fin[i], fout[i]);
    run_row(fsp_row_t'{0, 1, 1, CMD_WRITE, 16'h1000, 16'h0000, 0});
    run_row(fsp_row_t'{0, 1, 1, CMD_WRITE, 16'h0800, 16'h1800, 1});
    test_done();
  end
endmodule
